// *** hw/pdm_pkg.sv ***
/*
  constants, mode codes and control carrier for the power-down mode controller.
  assumes a single 10 MHz system clock and word-aligned AHB-Lite register access.
*/
// Contract
// (RULE_01) medium-speed mode clocks the processor at system clock over 2, 4, 8, 16 or 32.
// (RULE_02) subactive: processor on subclock, only both timers and both watchdogs keep running.
// (RULE_03) sleep: processor clock stopped, peripherals keep running.
// (RULE_04) subsleep: processor halted, only both timers and both watchdogs keep running.
// (RULE_05) watch: processor and all peripherals halted except the second watchdog.
// (RULE_06) software standby: oscillator stopped, processor and all peripherals stopped.
// (RULE_07) hardware standby: oscillator stopped, processor and peripherals held in reset.
// (RULE_08) each peripheral can be stopped alone through module halt bits, in any mode.
// (RULE_09) the four power registers are reachable only while the flash access switch is 0.
// (RULE_10) sleep from high/medium speed: standby select 0 gives sleep, 1 gives deeper modes.
// (RULE_11) sleep from subactive: standby select 0 gives subsleep, 1 gives watch or high speed.
// (RULE_12) interrupt-driven transitions leave the standby select bit unchanged.
// (RULE_13) leaving standby, watch or subactive waits the selected stabilization time; the code waits only on exits to high speed.
// (RULE_14) software picks at least 8 ms of wait for a crystal oscillator.
// (RULE_15) wait codes: 000 is 8192 states doubling to 262144 at 101, 111 is 16.
// (RULE_16) the 16-state wait must not be used on the flash-memory variant.
// (RULE_17) with an external clock software should pick the shortest wait.
// (RULE_18) standby control bit 3 always reads 0 and ignores writes.
// (RULE_19) bus clock select: 000 undivided, 001..101 divide by 2..32, 11X undefined.
// (RULE_20) software clears bus clock select before entering subactive or watch mode.
// (RULE_21) on watch release, low-speed flag 0 gives high speed, 1 gives subactive.
// (RULE_22) direct-transfer flag lets sleep switch directly between high speed and subactive.
// (RULE_23) stabilization wait is a state counter loaded on restart, releasing on expiry.
// (RULE_24) undefined bus clock codes keep the divider at its last valid setting.
package pdm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STBY_CTRL_OFF = 8'h00;
  localparam logic [7:0] LOW_PWR_OFF = 8'h04;
  localparam logic [7:0] HALT_HI_OFF = 8'h08;
  localparam logic [7:0] HALT_LO_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  localparam int STBY_SEL_BIT = 7;
  localparam int STS_LSB = 4;
  localparam int RSVD_BIT = 3;
  localparam int SCK_LSB = 0;
  localparam int DIRECT_XFER_BIT = 7;
  localparam int LOW_SPEED_BIT = 6;

  localparam logic [7:0] STBY_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_PWR_RST = 8'h00;
  localparam logic [7:0] HALT_HI_RST = 8'h00;
  localparam logic [7:0] HALT_LO_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int WAIT_BASE_STATES = 8192;
  localparam int WAIT_SHORT_STATES = 16;
  localparam logic [2:0] WAIT_LONG_CODE = 3'h5;
  localparam logic [2:0] WAIT_SHORT_CODE = 3'h7;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam int WAIT_CNT_W = 19;

  typedef enum logic [3:0] {
    MODE_RUN      = 4'h0,
    MODE_SLEEP    = 4'h1,
    MODE_SUBACT   = 4'h2,
    MODE_SUBSLEEP = 4'h3,
    MODE_WATCH    = 4'h4,
    MODE_SW_STBY  = 4'h5,
    MODE_HW_STBY  = 4'h6,
    MODE_OSC_WAIT = 4'h7
  } pwr_mode_e;

  typedef struct packed {
    logic cpu_clk_en;
    logic cpu_on_sub;
    logic periph_en;
    logic timer_channel_a_en;
    logic timer_channel_b_en;
    logic watchdog_a_en;
    logic watchdog_b_en;
    logic osc_en;
    logic periph_rst;
  } power_ctl_s;

endpackage

// *** hw/power_down_mode_control.sv ***
/*
  power-down mode controller: standby, low-power and module halt registers behind
  an AHB-Lite slave, mode sequencer, medium-speed divider and stabilization counter.
  assumes sleep_exec and wake_irq are one-cycle pulses from the core and interrupt
  controller, and that clock gating cells downstream act on the control outputs.
*/
`timescale 1ns/100ps
module power_down_mode_control
  import pdm_pkg::*;
#(
  parameter int WAIT_BASE = WAIT_BASE_STATES,
  parameter int WAIT_SHORT = WAIT_SHORT_STATES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core and system events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic hw_standby_req,
  input wire logic flash_reg_access_switch,
  // power control
  output power_ctl_s power_ctl,
  output logic [15:0] module_halt,
  output logic [3:0] power_mode,
  output logic [2:0] bus_clock_div
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pwr_mode_e mode_q, mode_d;
  logic load_wait;
  logic [WAIT_CNT_W-1:0] wait_cnt_q;
  logic [4:0] div_cnt_q;
  logic tick;
  logic standby_select_q;
  logic [2:0] wait_sel_q;
  logic [2:0] bus_clock_sel_q;
  logic [2:0] div_sel_q;
  logic [7:0] low_power_control_q;
  logic [7:0] halt_hi_q, halt_lo_q;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  power_ctl_s ctl_q;
  logic low_speed_flag, direct_transfer_flag, wr_ok;

  assign low_speed_flag = low_power_control_q[LOW_SPEED_BIT];
  assign direct_transfer_flag = low_power_control_q[DIRECT_XFER_BIT];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [WAIT_CNT_W-1:0] wait_len(input logic [2:0] sel);
    logic [WAIT_CNT_W-1:0] base;
    base = WAIT_CNT_W'(WAIT_BASE);
    if (sel == WAIT_SHORT_CODE) begin
      wait_len = WAIT_CNT_W'(WAIT_SHORT); // [RULE_15]
    end else if (sel > WAIT_LONG_CODE) begin
      wait_len = base << WAIT_LONG_CODE; // reserved code: safest is the longest wait
    end else begin
      wait_len = base << sel; // [RULE_15]
    end
  endfunction

  function automatic logic is_locked_reg(input logic [7:0] a);
    is_locked_reg = (a == STBY_CTRL_OFF) || (a == LOW_PWR_OFF) ||
                    (a == HALT_HI_OFF) || (a == HALT_LO_OFF);
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state
  // ----------------------------------------------------------------
  // the read wait state lets a read right behind a write see the new value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      hresp_q <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q <= 32'h0000_0000;
        if (!(flash_reg_access_switch && is_locked_reg(addr_q))) begin // [RULE_09]
          unique case (addr_q)
            STBY_CTRL_OFF: hrdata_q[7:0] <= {standby_select_q, wait_sel_q, 1'b0,
                                             bus_clock_sel_q}; // [RULE_18]
            LOW_PWR_OFF: hrdata_q[7:0] <= low_power_control_q;
            HALT_HI_OFF: hrdata_q[7:0] <= halt_hi_q;
            HALT_LO_OFF: hrdata_q[7:0] <= halt_lo_q;
            STATUS_OFF: hrdata_q[7:0] <= {1'b0, div_sel_q, mode_q};
            default: hrdata_q <= 32'h0000_0000;
          endcase
        end
      end else if (hsel && hready && htrans[1]) begin
        addr_q <= haddr[7:0];
        wr_pend_q <= hwrite;
        rd_pend_q <= !hwrite;
        hreadyout_q <= hwrite;
      end
    end
  end

  assign wr_ok = wr_pend_q && !(flash_reg_access_switch && is_locked_reg(addr_q)); // [RULE_09]

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // only bus writes touch the standby select bit, never a mode change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      standby_select_q <= STBY_CTRL_RST[STBY_SEL_BIT];
      wait_sel_q <= STBY_CTRL_RST[STS_LSB +: 3];
      bus_clock_sel_q <= STBY_CTRL_RST[SCK_LSB +: 3];
    end else if (wr_ok && addr_q == STBY_CTRL_OFF) begin // [RULE_12]
      standby_select_q <= hwdata[STBY_SEL_BIT];
      wait_sel_q <= hwdata[STS_LSB +: 3];
      bus_clock_sel_q <= hwdata[SCK_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_sel_q <= STBY_CTRL_RST[SCK_LSB +: 3];
    end else if (wr_ok && addr_q == STBY_CTRL_OFF && hwdata[SCK_LSB +: 3] <= DIV_MAX_CODE) begin
      div_sel_q <= hwdata[SCK_LSB +: 3]; // [RULE_24] [RULE_19]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_power_control_q <= LOW_PWR_RST;
    end else if (wr_ok && addr_q == LOW_PWR_OFF) begin
      low_power_control_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      halt_hi_q <= HALT_HI_RST;
      halt_lo_q <= HALT_LO_RST;
    end else if (wr_ok && addr_q == HALT_HI_OFF) begin
      halt_hi_q <= hwdata[7:0]; // [RULE_08]
    end else if (wr_ok && addr_q == HALT_LO_OFF) begin
      halt_lo_q <= hwdata[7:0]; // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    load_wait = 1'b0;
    if (hw_standby_req) begin
      mode_d = MODE_HW_STBY; // [RULE_07]
    end else begin
      unique case (mode_q)
        MODE_RUN: if (sleep_exec) begin
          if (!standby_select_q) mode_d = MODE_SLEEP; // [RULE_10]
          else if (!low_speed_flag) mode_d = MODE_SW_STBY; // [RULE_10]
          else if (direct_transfer_flag) mode_d = MODE_SUBACT; // [RULE_22]
          else mode_d = MODE_WATCH; // [RULE_10]
        end
        MODE_SLEEP: if (wake_irq) mode_d = MODE_RUN;
        MODE_SUBACT: if (sleep_exec) begin
          if (!standby_select_q) begin
            mode_d = MODE_SUBSLEEP; // [RULE_11]
          end else if (!low_speed_flag && direct_transfer_flag) begin
            mode_d = MODE_OSC_WAIT; // [RULE_22] [RULE_13]
            load_wait = 1'b1;
          end else begin
            mode_d = MODE_WATCH; // [RULE_11]
          end
        end
        MODE_SUBSLEEP: if (wake_irq) mode_d = MODE_SUBACT;
        MODE_WATCH: if (wake_irq) begin
          if (low_speed_flag) begin
            mode_d = MODE_SUBACT; // [RULE_21]
          end else begin
            mode_d = MODE_OSC_WAIT; // [RULE_21] [RULE_13]
            load_wait = 1'b1;
          end
        end
        MODE_SW_STBY: if (wake_irq) begin
          mode_d = MODE_OSC_WAIT; // [RULE_13]
          load_wait = 1'b1;
        end
        MODE_HW_STBY: begin
          mode_d = MODE_OSC_WAIT;
          load_wait = 1'b1;
        end
        MODE_OSC_WAIT: if (wait_cnt_q == '0) mode_d = MODE_RUN; // [RULE_23]
        default: mode_d = MODE_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // counts system clock states from oscillator restart
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt_q <= '0;
    end else if (load_wait) begin
      wait_cnt_q <= wait_len(wait_sel_q) - WAIT_CNT_W'(1); // [RULE_23] [RULE_13]
    end else if (mode_q == MODE_OSC_WAIT && wait_cnt_q != '0) begin
      wait_cnt_q <= wait_cnt_q - WAIT_CNT_W'(1); // [RULE_23]
    end
  end

  // ----------------------------------------------------------------
  // medium-speed divider and control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // divide by 2^sel: one enable per 2^sel system clocks
  assign tick = ((div_cnt_q & ((5'h01 << div_sel_q) - 5'h01)) ==
                 ((5'h01 << div_sel_q) - 5'h01)); // [RULE_01]

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= '0;
      unique case (mode_q)
        MODE_RUN: begin
          ctl_q.cpu_clk_en <= tick; // [RULE_01]
          ctl_q.periph_en <= 1'b1;
          ctl_q.timer_channel_a_en <= 1'b1;
          ctl_q.timer_channel_b_en <= 1'b1;
          ctl_q.watchdog_a_en <= 1'b1;
          ctl_q.watchdog_b_en <= 1'b1;
          ctl_q.osc_en <= 1'b1;
        end
        MODE_SLEEP: begin
          ctl_q.periph_en <= 1'b1; // [RULE_03]
          ctl_q.timer_channel_a_en <= 1'b1;
          ctl_q.timer_channel_b_en <= 1'b1;
          ctl_q.watchdog_a_en <= 1'b1;
          ctl_q.watchdog_b_en <= 1'b1;
          ctl_q.osc_en <= 1'b1;
        end
        MODE_SUBACT, MODE_SUBSLEEP: begin
          ctl_q.cpu_clk_en <= (mode_q == MODE_SUBACT); // [RULE_02] [RULE_04]
          ctl_q.cpu_on_sub <= 1'b1; // [RULE_02]
          ctl_q.timer_channel_a_en <= 1'b1;
          ctl_q.timer_channel_b_en <= 1'b1;
          ctl_q.watchdog_a_en <= 1'b1;
          ctl_q.watchdog_b_en <= 1'b1;
        end
        MODE_WATCH: ctl_q.watchdog_b_en <= 1'b1; // [RULE_05]
        MODE_SW_STBY: ctl_q <= '0; // [RULE_06]
        MODE_HW_STBY: ctl_q.periph_rst <= 1'b1; // [RULE_07]
        MODE_OSC_WAIT: ctl_q.osc_en <= 1'b1;
        default: ctl_q <= '0;
      endcase
    end
  end

  assign power_ctl = ctl_q;
  assign module_halt = {halt_hi_q, halt_lo_q};
  assign power_mode = mode_q;
  assign bus_clock_div = div_sel_q;
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_sleep_cpu_stop: assert property ( // [RULE_03]
    mode_q == MODE_SLEEP |=> !power_ctl.cpu_clk_en && power_ctl.periph_en && power_ctl.osc_en)
    else $error("sleep mode control wrong");
  chk_subact_periph_halt: assert property ( // [RULE_02]
    mode_q == MODE_SUBACT |=> power_ctl.cpu_on_sub && !power_ctl.periph_en &&
      power_ctl.timer_channel_b_en && power_ctl.watchdog_a_en && !power_ctl.osc_en)
    else $error("subactive control wrong");
  chk_subsleep_cpu_halt: assert property ( // [RULE_04]
    mode_q == MODE_SUBSLEEP |=> !power_ctl.cpu_clk_en && !power_ctl.periph_en &&
      power_ctl.timer_channel_a_en && power_ctl.watchdog_b_en)
    else $error("subsleep control wrong");
  chk_watch_only_wdt: assert property ( // [RULE_05]
    mode_q == MODE_WATCH |=> power_ctl == power_ctl_s'(9'h004))
    else $error("watch mode control wrong");
  chk_hw_standby_reset: assert property ( // [RULE_07]
    hw_standby_req ##1 hw_standby_req |=> power_ctl.periph_rst && !power_ctl.osc_en)
    else $error("hardware standby not held in reset");
  chk_sleep_entry_sel: assert property ( // [RULE_10]
    mode_q == MODE_RUN && sleep_exec && !hw_standby_req |=>
      (mode_q == MODE_SLEEP) == !$past(standby_select_q))
    else $error("sleep entry ignores standby select");
  chk_subsleep_entry_sel: assert property ( // [RULE_11]
    mode_q == MODE_SUBACT && sleep_exec && !hw_standby_req && !standby_select_q |=>
      mode_q == MODE_SUBSLEEP)
    else $error("subsleep not entered");
  chk_standby_select_stable_irq: assert property ( // [RULE_12]
    !(wr_ok && addr_q == STBY_CTRL_OFF) |=> $stable(standby_select_q))
    else $error("standby select changed without a write");
  chk_wait_release: assert property ( // [RULE_23]
    mode_q == MODE_OSC_WAIT && wait_cnt_q == '0 && !hw_standby_req |=> mode_q == MODE_RUN)
    else $error("wait expiry did not release");
  chk_wait_hold: assert property ( // [RULE_13]
    mode_q == MODE_OSC_WAIT && wait_cnt_q != '0 && !hw_standby_req |=>
      mode_q == MODE_OSC_WAIT && wait_cnt_q == $past(wait_cnt_q) - WAIT_CNT_W'(1))
    else $error("left wait before expiry");
  chk_div_by_two: assert property ( // [RULE_01]
    mode_q == MODE_RUN && $stable(mode_q) && div_sel_q == 3'h1 && $stable(div_sel_q) &&
      power_ctl.cpu_clk_en && !sleep_exec && !hw_standby_req |=> !power_ctl.cpu_clk_en)
    else $error("divide by two enable wrong");
  chk_div_valid: assert property (div_sel_q <= DIV_MAX_CODE) // [RULE_24]
    else $error("divider took an undefined code");
  chk_lock_write: assert property ( // [RULE_09]
    wr_pend_q && flash_reg_access_switch && addr_q == LOW_PWR_OFF |=>
      $stable(low_power_control_q))
    else $error("locked register was written");
  chk_rsvd_bit_zero: assert property ( // [RULE_18]
    $past(rd_pend_q) && $past(addr_q) == STBY_CTRL_OFF |-> !hrdata_q[RSVD_BIT])
    else $error("reserved bit read as one");

  cov_sw_standby_wake: cover property (mode_q == MODE_SW_STBY ##[1:20] mode_q == MODE_OSC_WAIT);
  cov_watch_to_subact: cover property (mode_q == MODE_WATCH ##1 mode_q == MODE_SUBACT);
  cov_direct_to_subact: cover property (mode_q == MODE_RUN ##1 mode_q == MODE_SUBACT);
  cov_locked_read: cover property (rd_pend_q && flash_reg_access_switch);

endmodule

// *** testbench/pdm_core_model.sv ***
/*
  core model: executes the sleep instruction when the bench asks for it.
  assumes req is a one-cycle request; the core only acts while its clock runs.
*/
`timescale 1ns/100ps
module pdm_core_model
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // bench request and controller state
  input wire logic req,
  input wire power_ctl_s power_ctl,
  // sleep instruction
  output logic sleep_exec
);
  // a stopped core executes nothing, so the request is gated by its clock enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_exec <= 1'b0;
    end else begin
      sleep_exec <= req & power_ctl.cpu_clk_en;
    end
  end
endmodule

// *** testbench/power_down_mode_control_tb.sv ***
/*
  self-checking bench for the power-down mode controller: AHB-Lite tasks,
  a core model for sleep instructions and a behavioural mode model.
  assumes the bus answers within a few cycles; every wait is bounded.
*/
`timescale 1ns/100ps
module power_down_mode_control_tb;
  import pdm_pkg::*;
  localparam int WB = 4;
  localparam int WS = 2;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic req = 1'b0;
  logic wake_irq = 1'b0;
  logic hw_req = 1'b0;
  logic lock = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sleep_exec;
  power_ctl_s power_ctl;
  logic [15:0] module_halt;
  logic [3:0] power_mode;
  logic [2:0] bus_clock_div;
  int err_count = 0;
  int num_checks = 0;
  int seed = 32'h5ee3;
  int m = 0;
  int stby_sel = 0;
  int low_speed = 0;
  int direct_xfer = 0;
  int sts = 0;
  int div = 0;
  int n;
  logic [31:0] rv;
  logic [7:0] hi;
  logic [7:0] lo;

  always #50 clock = ~clock;

  power_down_mode_control #(.WAIT_BASE(WB), .WAIT_SHORT(WS)) u_dut (
    .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .hw_standby_req(hw_req), .flash_reg_access_switch(lock),
    .power_ctl(power_ctl), .module_halt(module_halt), .power_mode(power_mode),
    .bus_clock_div(bus_clock_div));
  pdm_core_model u_core (.clock(clock), .rst_b(rst_b), .req(req),
    .power_ctl(power_ctl), .sleep_exec(sleep_exec));

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic int nm(input int k);
    if (k == 2) return 6;
    if (k == 3) return 7;
    if (k == 0 && m == 0) return !stby_sel ? 1 : !low_speed ? 5 : direct_xfer ? 2 : 4;
    if (k == 0 && m == 2) return !stby_sel ? 3 : (!low_speed && direct_xfer) ? 7 : 4;
    if (k == 1 && m == 1) return 0;
    if (k == 1 && m == 3) return 2;
    if (k == 1 && m == 4) return low_speed ? 2 : 7;
    if (k == 1 && m == 5) return 7;
    return m;
  endfunction

  function automatic int wl(input int c);
    return c == 7 ? WS : WB << (c > 5 ? 5 : c);
  endfunction

  // upper half is the mask: fields left open by the mode are not judged
  function automatic logic [17:0] ctl_exp(input int md);
    case (md)
      0: return {9'h1FF, 9'b101111110};
      1: return {9'h1FF, 9'b001111110};
      2: return {9'h1FF, 9'b110111100};
      3: return {9'b101111101, 9'b000111100};
      4: return {9'b101111111, 9'b000000100};
      5: return {9'b101111110, 9'b000000000};
      6: return {9'b000000011, 9'b000000001};
      default: return 18'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_ctl(input int md);
    logic [17:0] e;
    e = ctl_exp(md);
    num_checks++;
    if ((power_ctl & e[17:9]) !== e[8:0]) begin
      err_count++;
      $display("[FAIL] power_ctl expected %b seen %b", e[8:0], power_ctl & e[17:9]);
    end
  endtask

  task automatic hwait();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      cmp_val("bus timeout", 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rv = hrdata;
    cmp_val("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wsc(input logic [7:0] v);
    bus(1'b1, 8'h00, {24'h0, v});
    stby_sel = v[7];
    sts = v[6:4];
    if (v[2:0] <= 3'h5) div = v[2:0];
  endtask

  task automatic wlp(input logic [7:0] v);
    bus(1'b1, 8'h04, {24'h0, v});
    direct_xfer = v[7];
    low_speed = v[6];
  endtask

  // k: 0 sleep instruction, 1 wake interrupt, 2 hw standby on, 3 off
  task automatic ev(input int k);
    if (k == 0) req <= 1'b1;
    if (k == 1) wake_irq <= 1'b1;
    if (k == 2) hw_req <= 1'b1;
    if (k == 3) hw_req <= 1'b0;
    @(posedge clock);
    req <= 1'b0;
    wake_irq <= 1'b0;
    if (k == 0) @(posedge clock);
    // read at the next edge, before it updates: stimulus stays on rising edges
    @(posedge clock);
    m = nm(k);
    cmp_val("power_mode", m, {28'h0, power_mode});
  endtask

  task automatic ctl_chk();
    @(posedge clock);
    cmp_ctl(m);
  endtask

  task automatic osc_wait();
    n = 1;
    while (power_mode === 4'h7 && n < 400) begin
      @(posedge clock);
      if (power_mode === 4'h7) n++;
    end
    cmp_val("osc wait", wl(sts), n);
    if (n >= 400) begin
      print_verdict();
    end
    m = 0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, i == 5 ? 8'h20 : 8'(4 * i), 32'h0);
      cmp_val("reset value", 32'h0, rv);
    end
    cmp_ctl(0);
    wsc(8'hFF);
    bus(1'b0, 8'h00, 32'h0);
    cmp_val("standby_control", 32'hF7, rv);
    cmp_val("bus_clock_div", 32'h0, bus_clock_div);
    for (int c = 1; c < 7; c++) begin
      wsc(8'(c));
      repeat (2) @(posedge clock);
      cmp_val("bus_clock_div", div, bus_clock_div);
      n = 0;
      repeat (64) begin
        @(posedge clock);
        if (power_ctl.cpu_clk_en === 1'b1) n++;
      end
      cmp_val("cpu clock pulses", 64 >> div, n);
    end
    wsc(8'h00);
    wlp(8'h40);
    lock <= 1'b1;
    bus(1'b1, 8'h04, 32'h80);
    bus(1'b0, 8'h04, 32'h0);
    cmp_val("locked read", 32'h0, rv);
    bus(1'b0, 8'h10, 32'h0);
    cmp_val("status", (div << 4) | m, rv);
    lock <= 1'b0;
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b0, 8'h04, 32'h0);
    cmp_val("low_power_control", 32'h40, rv);
    repeat (3) begin
      hi = 8'($random(seed));
      lo = 8'($random(seed));
      bus(1'b1, 8'h08, {24'h0, hi});
      bus(1'b1, 8'h0C, {24'h0, lo});
      repeat (2) @(posedge clock);
      cmp_val("module_halt", {hi, lo}, module_halt);
    end
    wlp(8'h00);
    ev(0);
    ctl_chk();
    cmp_val("module_halt", {hi, lo}, module_halt);
    ev(1);
    // code 7 taken as on the mask variant
    for (int c = 0; c < 8; c++) begin
      wsc(8'h80 | 8'(c << 4));
      ev(0);
      ctl_chk();
      ev(1);
      osc_wait();
      bus(1'b0, 8'h00, 32'h0);
      cmp_val("standby_control", 8'h80 | 8'(c << 4), rv);
    end
    wlp(8'hC0);
    wsc(8'h80); // divider left at 0 before low-power entry
    ev(0);
    ctl_chk();
    wsc(8'h00);
    ev(0);
    ctl_chk();
    ev(1);
    wsc(8'h80);
    ev(0);
    ctl_chk();
    ev(1);
    wlp(8'h80);
    ev(0);
    osc_wait();
    wlp(8'h40);
    ev(0);
    wlp(8'h00);
    ev(1);
    osc_wait();
    ev(2);
    ctl_chk();
    ev(3);
    osc_wait();
    print_verdict();
  end
endmodule
